// ===== hdl/pic_pkg.sv
// package of constants and types for the primary interrupt controller
//
// Overview of operation
// [RQ1] fifteen request lines 1..15 each own a pending bit at their line number; bit 0 is reserved.
// [RQ2] the pending register is read-only, shows outstanding requests, reads zero above bit 15, resets to zero.
// [RQ3] lines 1..14 have a read-write enable bit at their line number; zero blocks, one passes.
// [RQ4] line 15 is non-maskable, has no enable bit and always reaches the processor when pending.
// [RQ5] lines 1..14 have a read-write priority bit at line plus 16; one means high level.
// [RQ6] bit 31 of the enable-and-level register reads one and cannot be written.
// [RQ7] enables and priorities reset to zero; bits 16 and 0 read zero.
// [RQ8] writing one to a force bit asserts that line as if requested; the bit reads back as written until that line is acknowledged, which clears it.
// [RQ9] force and clear bits 11, 8 and 5 are reserved zeros and have no effect.
// [RQ10] the clear register is write-only; a one removes that line's pending request, a zero does nothing.
// [RQ11] the highest numbered pending enabled high-level line wins, else the highest low-level one; acknowledge clears it.
package pic_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] PIC_OFS_ENLV  = 8'h00;
  localparam logic [7:0] PIC_OFS_PEND  = 8'h04;
  localparam logic [7:0] PIC_OFS_FORCE = 8'h08;
  localparam logic [7:0] PIC_OFS_CLEAR = 8'h0c;
  localparam logic [7:0] PIC_OFS_ISTAT = 8'h10;
  localparam logic [7:0] PIC_OFS_IMASK = 8'h14;

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int          PIC_NMI_LINE   = 15;
  localparam int          PIC_LEVEL_POS  = 16;
  localparam logic [15:0] PIC_LINE_MASK  = 16'hfffe;
  localparam logic [15:0] PIC_EN_MASK    = 16'h7ffe;
  localparam logic [15:0] PIC_FORCE_MASK = 16'hf6de;
  localparam logic [15:0] PIC_RST_ENABLE = 16'h0000;
  localparam logic [15:0] PIC_RST_LEVEL  = 16'h0000;
  localparam logic [15:0] PIC_RST_FORCE  = 16'h0000;
  localparam logic [15:0] PIC_RST_PEND   = 16'h0000;
  localparam logic [1:0]  PIC_RST_EVENT  = 2'h0;
  localparam logic [31:0] PIC_RDATA_ZERO = 32'h0000_0000;
  localparam logic [15:0] PIC_TOP_BIT_HI = 16'h8000;

  // event bits: 0 = new request taken, 1 = acknowledge done
  localparam int PIC_EV_TAKEN = 0;
  localparam int PIC_EV_ACK   = 1;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic        valid;
    logic [3:0]  line;
  } pic_sel_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pic_apb_req_t;

  typedef enum logic [1:0] {
    PIC_ST_IDLE,
    PIC_ST_ACCESS
  } pic_apb_st_t;

endpackage

// ===== hdl/pic_select.sv
// priority selection of the line presented to the processor
`timescale 1ns/10ps
`default_nettype none
module pic_select
  import pic_pkg::*;
(
  input  wire logic [15:0] i_pending,
  input  wire logic [15:0] i_enable,
  input  wire logic [15:0] i_level,
  output pic_sel_t         o_sel
);

  // ****************************************************************
  // selection
  // ****************************************************************
  function automatic pic_sel_t pic_highest(input logic [15:0] v);
    pic_sel_t r;
    r = '0;
    for (int i = 1; i < 16; i++) begin
      if (v[i]) begin
        r.valid = 1'b1;
        r.line  = 4'(i);
      end
    end
    return r;
  endfunction

  wire logic [15:0] active;
  wire logic [15:0] high_set;
  wire pic_sel_t    high_sel;
  wire pic_sel_t    low_sel;

  // nmi bypasses the enable and sits at high level
  assign active   = i_pending & (i_enable | PIC_TOP_BIT_HI) & PIC_LINE_MASK; // see [RQ4]
  assign high_set = active & (i_level | PIC_TOP_BIT_HI);                       // see [RQ6]
  assign high_sel = pic_highest(high_set);
  assign low_sel  = pic_highest(active & ~high_set);
  assign o_sel    = high_sel.valid ? high_sel : low_sel;                       // see [RQ11]

endmodule
`default_nettype wire

// ===== hdl/pic_top.sv
// primary interrupt controller with apb register slave
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module pic_top
  import pic_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [15:0] i_irq_lines,
  input  wire logic        i_irq_ack,
  output logic             o_irq_valid,
  output logic      [3:0]  o_irq_line,
  output logic             o_irq
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] enable_ff;
  logic [15:0] level_ff;
  logic [15:0] force_ff;
  logic [15:0] pend_ff;
  logic [15:0] lines_d_ff;
  logic [1:0]  istat_ff;
  logic [1:0]  imask_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        irq_valid_ff;
  logic [3:0]  irq_line_ff;
  logic        irq_ff;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire pic_apb_req_t req;
  wire logic         setup;
  wire logic         wr;
  wire logic         rd;
  wire logic         hit_enlv;
  wire logic         hit_pend;
  wire logic         hit_force;
  wire logic         hit_clear;
  wire logic         hit_istat;
  wire logic         hit_imask;
  wire logic         mapped;

  assign req       = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                       paddr: i_paddr, pwdata: i_pwdata};
  // answer comes one cycle after the access phase begins
  assign setup     = req.psel & req.penable & ~pready_ff;
  assign wr        = setup & req.pwrite;
  assign rd        = setup & ~req.pwrite;
  assign hit_enlv  = req.paddr == PIC_OFS_ENLV;
  assign hit_pend  = req.paddr == PIC_OFS_PEND;
  assign hit_force = req.paddr == PIC_OFS_FORCE;
  assign hit_clear = req.paddr == PIC_OFS_CLEAR;
  assign hit_istat = req.paddr == PIC_OFS_ISTAT;
  assign hit_imask = req.paddr == PIC_OFS_IMASK;
  assign mapped    = hit_enlv | hit_pend | hit_force | hit_clear | hit_istat | hit_imask;

  // ****************************************************************
  // pending logic
  // ****************************************************************
  wire pic_sel_t    sel;
  wire logic [15:0] rise;
  wire logic [15:0] clr_wr;
  wire logic [15:0] ack_clr;
  wire logic [15:0] new_force;
  wire logic [15:0] set_pend;
  wire logic        ack_take;
  wire logic [15:0] nxt_pend;
  wire logic [15:0] nxt_force;
  wire logic [1:0]  ev;
  wire logic [1:0]  nxt_istat;

  function automatic logic [15:0] pic_onehot(input logic [3:0] n);
    return 16'(1) << n;
  endfunction

  assign rise      = i_irq_lines & ~lines_d_ff & PIC_LINE_MASK;           // see [RQ1]
  assign clr_wr    = (wr & hit_clear) ? (i_pwdata[15:0] & PIC_FORCE_MASK) : 16'h0000; // see [RQ9]
  assign ack_take  = i_irq_ack & irq_valid_ff;
  assign ack_clr   = ack_take ? pic_onehot(irq_line_ff) : 16'h0000;       // see [RQ11]
  assign new_force = (wr & hit_force) ? (i_pwdata[15:0] & PIC_FORCE_MASK) : force_ff; // see [RQ8]
  // a newly written force bit raises its line like a source edge
  assign set_pend  = rise | (new_force & ~force_ff);
  // set wins over clear
  assign nxt_pend  = ((pend_ff & ~clr_wr & ~ack_clr) | set_pend) & PIC_LINE_MASK; // see [RQ10]
  assign nxt_force = new_force & ~ack_clr;
  assign ev        = {ack_take, |set_pend};
  assign nxt_istat = (istat_ff & ~((wr & hit_istat) ? i_pwdata[1:0] : 2'h0)) | ev;

  pic_select u_select (
    .i_pending (pend_ff),
    .i_enable  (enable_ff),
    .i_level   (level_ff),
    .o_sel     (sel)
  );

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire logic [31:0] rd_enlv;
  wire logic [31:0] rd_data;

  assign rd_enlv = {1'b1, level_ff[14:1], 1'b0, 1'b0, enable_ff[14:1], 1'b0}; // see [RQ6]
  assign rd_data = hit_enlv  ? rd_enlv :
                   hit_pend  ? {16'h0000, pend_ff} :                          // see [RQ2]
                   hit_force ? {16'h0000, force_ff} :
                   hit_istat ? {30'h0, istat_ff} :
                   hit_imask ? {30'h0, imask_ff} : PIC_RDATA_ZERO;

  // ****************************************************************
  // state
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      enable_ff <= PIC_RST_ENABLE;                                          // see [RQ7]
      level_ff  <= PIC_RST_LEVEL;
      imask_ff  <= PIC_RST_EVENT;
    end else if (wr & hit_enlv) begin
      enable_ff <= i_pwdata[15:0] & PIC_EN_MASK;                            // see [RQ3]
      level_ff  <= i_pwdata[31:16] & PIC_EN_MASK;                           // see [RQ5]
    end else if (wr & hit_imask) begin
      imask_ff  <= i_pwdata[1:0];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_ff    <= PIC_RST_PEND;
      force_ff   <= PIC_RST_FORCE;
      lines_d_ff <= PIC_RST_PEND;
      istat_ff   <= PIC_RST_EVENT;
    end else begin
      pend_ff    <= nxt_pend;
      force_ff   <= nxt_force;
      lines_d_ff <= i_irq_lines;
      istat_ff   <= nxt_istat;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      prdata_ff  <= PIC_RDATA_ZERO;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff  <= rd ? rd_data : PIC_RDATA_ZERO;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_valid_ff <= 1'b0;
      irq_line_ff  <= 4'h0;
      irq_ff       <= 1'b0;
    end else begin
      // hide the acknowledged line for the cycle its pending bit clears
      irq_valid_ff <= sel.valid & ~ack_take;
      irq_line_ff  <= sel.line;
      irq_ff       <= |(nxt_istat & imask_ff);
    end
  end

  assign o_prdata    = prdata_ff;
  assign o_pready    = pready_ff;
  assign o_pslverr   = pslverr_ff;
  assign o_irq_valid = irq_valid_ff;
  assign o_irq_line  = irq_line_ff;
  assign o_irq       = irq_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_pend_reserved;
    @(posedge i_ref_clk) disable iff (i_rst) pend_ff[0] == 1'b0;
  endproperty
  a_pend_reserved: assert property (p_pend_reserved) else $error("pending bit 0 set"); // see [RQ1]

  property p_pend_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (rd & hit_pend) |=> (o_pready && o_prdata == {16'h0000, $past(pend_ff)});
  endproperty
  a_pend_read: assert property (p_pend_read) else $error("pending read mismatch"); // see [RQ2]

  property p_enlv_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (rd & hit_enlv) |=> (o_prdata[31] && !o_prdata[16] && !o_prdata[15] && !o_prdata[0]);
  endproperty
  a_enlv_read: assert property (p_enlv_read) else $error("fixed bits wrong"); // see [RQ6]

  property p_enable_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      (wr & hit_enlv) |=> (enable_ff == ($past(i_pwdata[15:0]) & PIC_EN_MASK)
                           && level_ff == ($past(i_pwdata[31:16]) & PIC_EN_MASK));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost"); // see [RQ3]

  property p_nmi_through;
    @(posedge i_ref_clk) disable iff (i_rst)
      (pend_ff[PIC_NMI_LINE] && !ack_take) |=> (o_irq_valid && o_irq_line == 4'hf);
  endproperty
  a_nmi_through: assert property (p_nmi_through) else $error("nmi not presented"); // see [RQ4]

  property p_force_sets;
    @(posedge i_ref_clk) disable iff (i_rst)
      (wr & hit_force & i_pwdata[1] & ~force_ff[1]) |=> pend_ff[1];
  endproperty
  a_force_sets: assert property (p_force_sets) else $error("force did not pend"); // see [RQ8]

  property p_reserved_force;
    @(posedge i_ref_clk) disable iff (i_rst)
      (force_ff & ~PIC_FORCE_MASK) == 16'h0000;
  endproperty
  a_reserved_force: assert property (p_reserved_force) else $error("reserved force bit"); // see [RQ9]

  property p_clear_works;
    @(posedge i_ref_clk) disable iff (i_rst)
      (wr & hit_clear & i_pwdata[15] & ~set_pend[15]) |=> !pend_ff[15];
  endproperty
  a_clear_works: assert property (p_clear_works) else $error("clear ignored"); // see [RQ10]

  property p_ack_clears;
    @(posedge i_ref_clk) disable iff (i_rst)
      (ack_take && !set_pend[irq_line_ff]) |=> !pend_ff[$past(irq_line_ff)];
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear"); // see [RQ11]

  property p_reset_state;
    @(posedge i_ref_clk) $fell(i_rst) |-> (enable_ff == 16'h0000 && level_ff == 16'h0000);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset values wrong"); // see [RQ7]

  property p_level_bounds;
    @(posedge i_ref_clk) disable iff (i_rst)
      (level_ff[0] == 1'b0) && (level_ff[15] == 1'b0);
  endproperty
  a_level_bounds: assert property (p_level_bounds) else $error("level bits out of range"); // see [RQ5]

endmodule
`default_nettype wire

// ===== tb/pic_core_model.sv
// processor core stand-in that acknowledges presented interrupts
`timescale 1ns/10ps
`default_nettype none
module pic_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_go,
  input  wire logic       i_valid,
  input  wire logic [2:0] i_wait,
  output logic            o_ack
);
  logic [2:0] cnt_ff;

  // one-cycle acknowledge once a line has been shown for i_wait plus one cycles;
  // dropping it at once keeps acks at least two cycles apart
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= 3'h0;
      o_ack  <= 1'b0;
    end else if (o_ack || !i_go || !i_valid) begin
      cnt_ff <= 3'h0;
      o_ack  <= 1'b0;
    end else if (cnt_ff == i_wait) begin
      o_ack <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the primary interrupt controller
`timescale 1ns/10ps
`default_nettype none
module tb
  import pic_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] lines = 16'h0;
  logic [3:0]  irq_line;
  logic [2:0]  wt = 3'h0;
  logic        pready, pslverr, irq_valid, irq, ack, er;
  int          seed = 32'hf34a0526;
  int          n_fail = 0, num_checks = 0, cyc = 0, i;
  int          en = 0, lv = 0, frc = 0, pend = 0, ack_line;

  always #2 clk = ~clk;

  pic_top uut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_irq_lines(lines), .i_irq_ack(ack),
    .o_irq_valid(irq_valid), .o_irq_line(irq_line), .o_irq(irq));
  pic_core_model core (.i_clk(clk), .i_rst(rst), .i_go(go), .i_valid(irq_valid),
    .i_wait(wt), .o_ack(ack));

  // ****************************************************************
  // reference model and helpers
  // ****************************************************************
  function automatic int pick();
    int c;
    int b;
    c = pend & (en | 32'h8000) & (lv | 32'h8000);
    if (c == 0) c = pend & (en | 32'h8000);
    pick = 0;
    for (b = 1; b < 16; b++) if (c[b]) pick = b;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0, rd, er);
    chk(nm, e, rd);
  endtask

  // each acknowledged line must be the one the model would choose
  always @(posedge clk) begin
    if (!rst && ack === 1'b1 && irq_valid === 1'b1) begin
      ack_line = pick();
      chk("line", ack_line, irq_line);
      pend = pend & ~(1 << ack_line);
      frc = frc & ~(1 << ack_line);
    end
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // program, clear, force, pulse sources, then let the core drain
  task automatic round(input logic [31:0] d, input logic [15:0] c, f, s);
    en = d[15:0] & 16'h7ffe;
    lv = d[31:16] & 16'h7ffe;
    wr(PIC_OFS_ENLV, d);
    rdc(PIC_OFS_ENLV, (d & 32'h7ffe7ffe) | 32'h80000000, "enlv");
    wr(PIC_OFS_CLEAR, {16'hffff, c});
    pend = pend & ~(c & 16'hf6de);
    wr(PIC_OFS_FORCE, {16'hffff, f});
    pend = pend | (f & 16'hf6de & ~frc);
    frc = f & 16'hf6de;
    rdc(PIC_OFS_FORCE, frc, "force");
    @(posedge clk);
    lines <= s;
    @(posedge clk);
    lines <= 16'h0;
    pend = pend | (s & 16'hfffe);
    wr(PIC_OFS_PEND, 32'hffffffff);
    rdc(PIC_OFS_PEND, pend, "pend");
    go <= 1'b1;
    while ((pend & (en | 32'h8000)) != 0) @(posedge clk);
    repeat (3) @(posedge clk);
    go <= 1'b0;
    #1;
    chk("valid", 0, irq_valid);
    rdc(PIC_OFS_PEND, pend, "pend_after");
    rdc(PIC_OFS_FORCE, frc, "force_after");
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc(PIC_OFS_ENLV, 32'h80000000, "enlv_rst");
    rdc(PIC_OFS_PEND, 0, "pend_rst");
    rdc(PIC_OFS_FORCE, 0, "force_rst");
    apb(1'b0, 8'h18, 32'h0, rd, er);
    chk("unmapped_data", 0, rd);
    chk("unmapped_err", 1, er);
    wr(PIC_OFS_ISTAT, 3);
    wr(PIC_OFS_IMASK, 0);
    round(0, 0, 16'h8002, 0);
    rdc(PIC_OFS_ISTAT, 3, "istat");
    chk("irq_masked", 0, irq);
    wr(PIC_OFS_IMASK, 2);
    repeat (2) @(posedge clk);
    #1;
    chk("irq_set", 1, irq);
    wr(PIC_OFS_ISTAT, 2);
    repeat (2) @(posedge clk);
    #1;
    chk("irq_clr", 0, irq);
    for (i = 0; i < 12; i++) begin
      wt <= 3'($random(seed));
      round($random(seed), 16'($random(seed)), 16'($random(seed)), 16'($random(seed)));
    end
    summarize();
  end
endmodule
`default_nettype wire
